/* File: idc_pkg.sv */
`default_nettype none
package idc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] DATA_CMD_OFFSET = 8'h10;
  localparam logic [31:0] DATA_CMD_RESET = 32'h0000_0000;

  // ==========================================================
  // Field layout of one queue entry and of the port
  localparam int BYTE_LSB = 0;
  localparam int BYTE_MSB = 7;
  localparam int CMD_BIT = 8;
  localparam int STOP_BIT = 9;
  localparam int RESTART_BIT = 10;
  localparam int FIRST_BIT = 11;
  localparam int ENTRY_W = 11;
  localparam int TX_DEPTH = 8;

  // Direction encodings
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // ==========================================================
  // Bus engine operation codes
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_RESTART = 3'h2;
  localparam logic [2:0] OP_STOP = 3'h3;
  localparam logic [2:0] OP_BYTE = 3'h4;

  // ==========================================================
  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_START = 6'b000010,
    ST_BYTE  = 6'b000100,
    ST_NEXT  = 6'b001000,
    ST_STOP  = 6'b010000,
    ST_RSTRT = 6'b100000
  } idc_state_e;
endpackage
`default_nettype wire

/* File: idc_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module idc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push;
  wire pop;

  // ==========================================================
  // Handshakes
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // Storage array, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: idc_data_command.sv */
`timescale 1ns/10ps
`default_nettype none
module idc_data_command #(
  parameter int AW = 8,
  parameter int DEPTH = idc_pkg::TX_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_wr_ready,
  // Configuration levels
  input wire logic master_mode,
  input wire logic repeated_start_allow,
  input wire logic special_cmd,
  input wire logic gc_or_start,
  input wire logic abort_clear,
  // Status
  output logic transmit_abort_flag,
  output logic rx_byte_ready,
  output logic scl_hold_low,
  // Bus engine operations
  output logic op_req,
  output logic [2:0] op_code,
  output logic op_dir,
  output logic [7:0] op_byte,
  output logic op_ack_next,
  input wire logic op_done,
  // Bus engine events
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_first,
  input wire logic slave_rd_req
);
  // ==========================================================
  // Declarations
  idc_pkg::idc_state_e state_reg, state_next;
  logic [2:0] op_code_reg, op_code_next;
  logic op_dir_reg, op_dir_next;
  logic [7:0] op_byte_reg, op_byte_next;
  logic prev_dir_reg, prev_dir_next;
  logic stop_after_reg, stop_after_next;
  logic start_after_reg, start_after_next;
  logic in_xfer_reg, in_xfer_next;
  logic pop_seq;
  logic abort_seq;
  logic [7:0] rx_data_reg;
  logic rx_first_reg;
  logic rx_full_reg;
  logic rd_req_pend_reg;
  logic abort_reg;
  logic [31:0] rdata_reg;

  wire sel_port;
  wire port_wr;
  wire port_rd;
  wire [idc_pkg::ENTRY_W-1:0] wr_entry;
  wire wr_is_read;
  wire gc_mode;
  wire abort_on_wr;
  wire push_valid;
  wire q_valid;
  wire [idc_pkg::ENTRY_W-1:0] q_entry;
  wire q_pop;
  wire head_dir;
  wire head_stop;
  wire head_restart;
  wire head_illegal;
  wire need_restart;
  wire slave_go;
  wire tx_ready_w;

  // ==========================================================
  // Register port decode
  assign sel_port = (reg_addr == AW'(idc_pkg::DATA_CMD_OFFSET));
  assign port_wr = reg_wr && sel_port;
  assign port_rd = reg_rd && sel_port;
  assign wr_is_read = reg_wdata[idc_pkg::CMD_BIT];
  // General call stays in force while the special bit is set and gc_or_start is low
  assign gc_mode = special_cmd && !gc_or_start;

  // Read entry data dropped
  // Zeroing the byte keeps stale write data from reaching the engine
  assign wr_entry = {reg_wdata[idc_pkg::RESTART_BIT],
                     reg_wdata[idc_pkg::STOP_BIT],
                     wr_is_read,
                     wr_is_read ? 8'h00 : reg_wdata[idc_pkg::BYTE_MSB:idc_pkg::BYTE_LSB]};

  // Read after request aborts
  // The bad entry is refused so the slave never sends a garbage byte
  assign abort_on_wr = port_wr && wr_is_read && !master_mode && rd_req_pend_reg;

  assign push_valid = port_wr && !abort_on_wr;
  // Write stalls while the queue is full
  assign reg_wr_ready = tx_ready_w;

  // ==========================================================
  // Transmit queue
  idc_fifo #(
    .WIDTH(idc_pkg::ENTRY_W),
    .DEPTH(DEPTH)
  ) i_idc_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(tx_ready_w),
    .in_data(wr_entry),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_entry)
  );

  // ==========================================================
  // Head entry fields
  // Bits used per entry only
  assign head_dir = q_entry[idc_pkg::CMD_BIT];
  assign head_stop = q_entry[idc_pkg::STOP_BIT];
  assign head_restart = q_entry[idc_pkg::RESTART_BIT];
  assign head_illegal = master_mode && gc_mode && (head_dir == idc_pkg::DIR_READ);
  assign need_restart = head_restart || (head_dir != prev_dir_reg);
  // Slave transmits every queued entry as a write, read entries with a zero byte
  // Slave receiver never consumes entries, so none are needed there
  assign slave_go = !master_mode && rd_req_pend_reg && q_valid;
  assign q_pop = pop_seq;

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    op_code_next = op_code_reg;
    op_dir_next = op_dir_reg;
    op_byte_next = op_byte_reg;
    prev_dir_next = prev_dir_reg;
    stop_after_next = stop_after_reg;
    start_after_next = start_after_reg;
    in_xfer_next = in_xfer_reg;
    pop_seq = 1'b0;
    abort_seq = 1'b0;
    case (state_reg)
      idc_pkg::ST_IDLE: begin
        op_code_next = idc_pkg::OP_NONE;
        if (master_mode && q_valid && head_illegal) begin
          pop_seq = 1'b1;
          abort_seq = 1'b1;
        end else if (master_mode && q_valid) begin
          op_code_next = idc_pkg::OP_START;
          state_next = idc_pkg::ST_START;
        end else if (slave_go) begin
          pop_seq = 1'b1;
          op_code_next = idc_pkg::OP_BYTE;
          op_dir_next = idc_pkg::DIR_WRITE;
          op_byte_next = q_entry[idc_pkg::BYTE_MSB:idc_pkg::BYTE_LSB];
          stop_after_next = 1'b0;
          state_next = idc_pkg::ST_BYTE;
        end
      end
      idc_pkg::ST_START, idc_pkg::ST_RSTRT: begin
        if (op_done) begin
          in_xfer_next = 1'b1;
          state_next = idc_pkg::ST_NEXT;
          op_code_next = idc_pkg::OP_NONE;
          // Head is taken without a restart check after a START
          start_after_next = 1'b1;
        end
      end
      idc_pkg::ST_BYTE: begin
        if (op_done) begin
          op_code_next = idc_pkg::OP_NONE;
          if (!master_mode) begin
            state_next = idc_pkg::ST_IDLE;
          end else if (stop_after_reg) begin
            op_code_next = idc_pkg::OP_STOP;
            state_next = idc_pkg::ST_STOP;
          end else begin
            state_next = idc_pkg::ST_NEXT;
          end
        end
      end
      idc_pkg::ST_NEXT: begin
        // Empty queue stalls bus
        // Clock is held low here by scl_hold_low until an entry arrives
        if (q_valid && head_illegal) begin
          pop_seq = 1'b1;
          abort_seq = 1'b1;
          op_code_next = idc_pkg::OP_STOP;
          state_next = idc_pkg::ST_STOP;
        end else if (q_valid && !start_after_reg && need_restart) begin
          if (repeated_start_allow) begin
            op_code_next = idc_pkg::OP_RESTART;
            state_next = idc_pkg::ST_RSTRT;
          end else begin
            op_code_next = idc_pkg::OP_STOP;
            state_next = idc_pkg::ST_STOP;
          end
        end else if (q_valid) begin
          pop_seq = 1'b1;
          start_after_next = 1'b0;
          op_code_next = idc_pkg::OP_BYTE;
          op_dir_next = head_dir;
          prev_dir_next = head_dir;
          op_byte_next = q_entry[idc_pkg::BYTE_MSB:idc_pkg::BYTE_LSB];
          stop_after_next = head_stop;
          state_next = idc_pkg::ST_BYTE;
        end
      end
      idc_pkg::ST_STOP: begin
        if (op_done) begin
          in_xfer_next = 1'b0;
          stop_after_next = 1'b0;
          op_code_next = idc_pkg::OP_NONE;
          // Restart if entries remain
          // Idle sees the queued entry at once and issues a new START
          state_next = idc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = idc_pkg::ST_IDLE;
        op_code_next = idc_pkg::OP_NONE;
      end
    endcase
  end

  // Ack the current read only when another read follows in the same transfer
  // Ack needs queued read
  wire ack_live = op_dir_reg && !stop_after_reg && q_valid &&
                  (q_entry[idc_pkg::CMD_BIT] == idc_pkg::DIR_READ) &&
                  !q_entry[idc_pkg::RESTART_BIT];

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= idc_pkg::ST_IDLE;
      op_code_reg <= idc_pkg::OP_NONE;
      op_dir_reg <= idc_pkg::DIR_WRITE;
      op_byte_reg <= 8'h00;
      prev_dir_reg <= idc_pkg::DIR_WRITE;
      stop_after_reg <= 1'b0;
      start_after_reg <= 1'b0;
      in_xfer_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_code_reg <= op_code_next;
      op_dir_reg <= op_dir_next;
      op_byte_reg <= op_byte_next;
      prev_dir_reg <= prev_dir_next;
      stop_after_reg <= stop_after_next;
      start_after_reg <= start_after_next;
      in_xfer_reg <= in_xfer_next;
    end
  end

  // ==========================================================
  // Engine outputs
  assign op_req = (op_code_reg != idc_pkg::OP_NONE);
  assign op_code = op_code_reg;
  assign op_dir = op_dir_reg;
  assign op_byte = op_byte_reg;
  assign op_ack_next = ack_live;
  assign scl_hold_low = (state_reg == idc_pkg::ST_NEXT) && in_xfer_reg && !q_valid;

  // ==========================================================
  // Abort flag and slave request, set wins over clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      abort_reg <= 1'b0;
      rd_req_pend_reg <= 1'b0;
    end else begin
      if (abort_seq || abort_on_wr) begin
        abort_reg <= 1'b1;
      end else if (abort_clear) begin
        abort_reg <= 1'b0;
      end
      if (slave_rd_req) begin
        rd_req_pend_reg <= 1'b1;
      end else if (slave_go || abort_on_wr) begin
        rd_req_pend_reg <= 1'b0;
      end
    end
  end
  assign transmit_abort_flag = abort_reg;

  // ==========================================================
  // Receive holding register; a new byte overwrites an unread one
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_data_reg <= 8'h00;
      rx_first_reg <= 1'b0;
      rx_full_reg <= 1'b0;
    end else begin
      if (rx_valid) begin
        rx_data_reg <= rx_byte;
        rx_first_reg <= rx_first;
        rx_full_reg <= 1'b1;
      end else if (port_rd) begin
        rx_full_reg <= 1'b0;
      end
    end
  end
  assign rx_byte_ready = rx_full_reg;

  // ==========================================================
  // Read data, control bits always read as zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_reg <= idc_pkg::DATA_CMD_RESET;
    end else if (reg_rd) begin
      rdata_reg <= sel_port ? {20'h0_0000, rx_first_reg, 3'h0, rx_data_reg} : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

/* File: idc_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bus engine stand-in: ends each operation after a short or long wait
module idc_engine_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Operations
  input wire logic slow,
  input wire logic op_req,
  input wire logic [2:0] op_code,
  input wire logic op_dir,
  output logic op_done,
  // Received bytes
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_first
);
  logic [3:0] wait_reg;
  logic first_reg;
  logic [7:0] data_reg;
  wire logic fire = op_req && !op_done && wait_reg == (slow ? 4'h5 : 4'h1);
  // Byte line is scrambled outside its pulse so a stale read shows up
  assign rx_byte = rx_valid ? data_reg : ~data_reg;
  // Done is one pulse; the count restarts so each operation is timed afresh
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_reg <= 4'h0;
      op_done <= 1'b0;
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      first_reg <= 1'b0;
      data_reg <= 8'h3c;
    end else begin
      op_done <= fire;
      rx_valid <= fire && op_code == idc_pkg::OP_BYTE && op_dir;
      wait_reg <= (op_req && !op_done && !fire) ? wait_reg + 4'h1 : 4'h0;
      if (fire && (op_code == idc_pkg::OP_START || op_code == idc_pkg::OP_RESTART)) begin
        first_reg <= 1'b1;
      end
      if (fire && op_code == idc_pkg::OP_BYTE && op_dir) begin
        rx_first <= first_reg;
        first_reg <= 1'b0;
        data_reg <= data_reg + 8'h35;
      end
    end
  end
endmodule
`default_nettype wire

/* File: idc_data_command_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker for the data and command block
module idc_data_command_sva #(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_wr_ready,
  // Levels and status
  input wire logic master_mode,
  input wire logic special_cmd,
  input wire logic gc_or_start,
  input wire logic abort_clear,
  input wire logic transmit_abort_flag,
  input wire logic rx_byte_ready,
  input wire logic scl_hold_low,
  // Bus engine
  input wire logic op_req,
  input wire logic [2:0] op_code,
  input wire logic op_dir,
  input wire logic [7:0] op_byte,
  input wire logic op_done,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte
);
  wire logic port_hit = reg_addr == AW'(idc_pkg::DATA_CMD_OFFSET);
  wire logic gc_read = master_mode && special_cmd && !gc_or_start && reg_wr && port_hit
    && reg_wr_ready && reg_wdata[8];
  // Last byte the engine handed over; a port read must return it
  logic [7:0] rx_seen_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_seen_reg <= 8'h00;
    end else if (rx_valid) begin
      rx_seen_reg <= rx_byte;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================
  // Assertions
  op_hold_a: assert property (
    op_req && !op_done |=> op_req && $stable({op_code, op_dir, op_byte}))
    else $error("operation changed before done");
  read_byte_a: assert property (
    op_req && op_code == idc_pkg::OP_BYTE && op_dir |-> op_byte == 8'h00)
    else $error("read carries a data byte");
  stall_hold_a: assert property (scl_hold_low |-> master_mode && !op_req)
    else $error("clock held low while busy");
  gc_abort_a: assert property (gc_read |-> ##[1:300] transmit_abort_flag)
    else $error("read after general call not aborted");
  abort_keep_a: assert property (
    transmit_abort_flag && !abort_clear |=> transmit_abort_flag)
    else $error("abort flag dropped");
  rx_flag_a: assert property (rx_valid && !reg_rd |=> rx_byte_ready)
    else $error("received byte not flagged");
  rx_data_a: assert property (
    reg_rd && port_hit && !rx_valid |=> reg_rdata[7:0] == rx_seen_reg)
    else $error("port read lost received byte");
  unmapped_a: assert property (
    reg_rd && !port_hit ##1 !reg_rd |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  restart_seen_c: cover property (op_req && op_done && op_code == idc_pkg::OP_RESTART);
  stall_seen_c: cover property (scl_hold_low);
  abort_seen_c: cover property ($rose(transmit_abort_flag));
endmodule
bind idc_data_command idc_data_command_sva #(.AW(AW)) i_idc_data_command_sva (
  .clk_sys, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_wr_ready,
  .master_mode, .special_cmd, .gc_or_start, .abort_clear, .transmit_abort_flag,
  .rx_byte_ready, .scl_hold_low, .op_req, .op_code, .op_dir, .op_byte, .op_done,
  .rx_valid, .rx_byte
);
`default_nettype wire

/* File: tb_i2c_data_command_word.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Compare helper: every call counted, a mismatch reported at once
`define CHK(name, exp, got) \
  checks_done++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("wrong value %s expected %h seen %h", name, exp, got); \
  end
module tb_i2c_data_command_word;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h10;
  logic [31:0] reg_wdata = 32'h0;
  logic master_mode = 1'b1;
  logic repeated_start_allow = 1'b1;
  logic special_cmd = 1'b0;
  logic gc_or_start = 1'b0;
  logic abort_clear = 1'b0;
  logic slave_rd_req = 1'b0;
  logic slow = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] op_byte, rx_byte;
  logic [2:0] op_code;
  logic reg_wr_ready, transmit_abort_flag, rx_byte_ready, scl_hold_low;
  logic op_req, op_dir, op_done, rx_valid, rx_first, op_ack_next;
  logic [12:0] ops[$], exp_ops[$];
  logic [12:0] got_op;
  logic [10:0] ents[$];
  logic [8:0] last_rx;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // ==========================================
  // Block and engine stand-in
  idc_data_command i_idc_data_command (
    .clk_sys, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_wr_ready,
    .master_mode, .repeated_start_allow, .special_cmd, .gc_or_start, .abort_clear,
    .transmit_abort_flag, .rx_byte_ready, .scl_hold_low, .op_req, .op_code, .op_dir,
    .op_byte, .op_ack_next, .op_done, .rx_valid, .rx_byte, .rx_first, .slave_rd_req
  );
  idc_engine_model i_idc_engine_model (
    .clk_sys, .reset, .slow, .op_req, .op_code, .op_dir, .op_done, .rx_valid, .rx_byte,
    .rx_first
  );
  always #50 clk_sys = ~clk_sys;
  // Log finished operations and received bytes; a hang ends the run
  always @(posedge clk_sys) begin
    cycles++;
    if (op_req && op_done) ops.push_back({op_code, op_dir, op_byte, op_ack_next});
    if (rx_valid) last_rx = {rx_first, rx_byte};
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Register port; strobes stay up across back-to-back writes
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
  endtask
  task automatic quiet();
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    `CHK(name, exp, reg_rdata)
  endtask
  task automatic pulse_rd_req();
    slave_rd_req = 1'b1;
    @(negedge clk_sys);
    slave_rd_req = 1'b0;
  endtask
  // Expected operations for the queued entries; returns 1 when left mid-transfer
  function automatic bit build(input logic allow);
    bit inx;
    logic pd;
    logic ack;
    exp_ops.delete();
    inx = 0;
    pd = 0;
    foreach (ents[i]) begin
      if (!inx) begin
        exp_ops.push_back({idc_pkg::OP_START, 10'h0});
      end else if (ents[i][10] || ents[i][8] != pd) begin
        if (allow) begin
          exp_ops.push_back({idc_pkg::OP_RESTART, 10'h0});
        end else begin
          exp_ops.push_back({idc_pkg::OP_STOP, 10'h0});
          exp_ops.push_back({idc_pkg::OP_START, 10'h0});
        end
      end
      pd = ents[i][8];
      // Read acked only while another read of the transfer is queued
      ack = 1'b0;
      if (i + 1 < ents.size()) ack = pd && !ents[i][9] && ents[i+1][8] && !ents[i+1][10];
      exp_ops.push_back({idc_pkg::OP_BYTE, pd, pd ? 8'h00 : ents[i][7:0], ack});
      inx = !ents[i][9];
      if (ents[i][9]) exp_ops.push_back({idc_pkg::OP_STOP, 10'h0});
    end
    return inx;
  endfunction
  // Slave byte: always a write, read-entry data dropped, never acked
  function automatic logic [12:0] slave_exp(input logic [10:0] e);
    return {idc_pkg::OP_BYTE, 1'b0, e[8] ? 8'h00 : e[7:0], 1'b0};
  endfunction
  task automatic wait_ops(input int cnt);
    int k;
    k = 0;
    while (ops.size() < cnt && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  // Only the code is compared for operations other than a byte
  task automatic cmp_ops();
    logic [12:0] got;
    wait_ops(exp_ops.size());
    repeat (8) @(negedge clk_sys);
    `CHK("op count", exp_ops.size(), ops.size())
    foreach (exp_ops[i]) begin
      got = i < ops.size() ? ops[i] : 13'h1fff;
      if (exp_ops[i][12:10] != idc_pkg::OP_BYTE) got[9:0] = exp_ops[i][9:0];
      `CHK("operation", exp_ops[i], got)
    end
    ops.delete();
  endtask
  // Random master entries, then a closing entry after any stall
  task automatic master_round(input int r);
    logic [10:0] e;
    int k;
    bit stall;
    bit rd_any;
    repeated_start_allow = r[0];
    slow = r[1];
    ents.delete();
    repeat (2 + $urandom % 6) ents.push_back(11'($urandom));
    if (r < 2) begin
      ents[0][9] = 1'b0;
      ents[1][10:8] = {2'b10, ents[0][8]};
    end
    put(8'h14, 32'h0000_0155);
    foreach (ents[i]) put(8'h10, {21'h0, ents[i]});
    quiet();
    stall = build(repeated_start_allow);
    k = exp_ops.size();
    cmp_ops();
    `CHK("clock held low", stall, scl_hold_low)
    e = {2'b01, 9'($urandom)};
    ents.push_back(e);
    put(8'h10, {21'h0, e});
    quiet();
    void'(build(repeated_start_allow));
    repeat (k) void'(exp_ops.pop_front());
    cmp_ops();
    `CHK("bus released", 1'b0, op_req)
    rd_any = 0;
    foreach (ents[i]) rd_any |= ents[i][8];
    if (rd_any) begin
      rd(8'h10, {20'h0, last_rx[8], 3'h0, last_rx[7:0]}, "received byte");
      `CHK("byte waiting", 1'b0, rx_byte_ready)
    end
    $display("test master %0d done", r);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(21));
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    rd(8'h10, 32'h0, "port after reset");
    rd(8'h20, 32'h0, "unmapped read");
    for (int r = 0; r < 6; r++) master_round(r);
    // Slave: fill until refused, then one entry per read request
    master_mode = 1'b0;
    ents.delete();
    repeat (8) ents.push_back({3'b000, 8'($urandom)});
    ents[3][8] = 1'b1;
    foreach (ents[i]) put(8'h10, {21'h0, ents[i]});
    quiet();
    `CHK("queue full", 1'b0, reg_wr_ready)
    put(8'h10, 32'h0000_00ee);
    quiet();
    foreach (ents[i]) begin
      pulse_rd_req();
      wait_ops(1);
      got_op = ops.pop_front();
      `CHK("slave byte", slave_exp(ents[i]), got_op)
    end
    // A request with the queue drained must find nothing to send
    pulse_rd_req();
    repeat (10) @(negedge clk_sys);
    `CHK("refused write", 0, ops.size())
    pulse_rd_req();
    put(8'h10, 32'h0000_01aa);
    quiet();
    `CHK("slave read abort", 1'b1, transmit_abort_flag)
    abort_clear = 1'b1;
    @(negedge clk_sys);
    abort_clear = 1'b0;
    `CHK("abort cleared", 1'b0, transmit_abort_flag)
    put(8'h10, 32'h0000_0042);
    quiet();
    pulse_rd_req();
    wait_ops(1);
    got_op = ops.pop_front();
    `CHK("slave byte", slave_exp(11'h042), got_op)
    $display("test slave done");
    // General call: a read entry aborts until the special bit is cleared
    master_mode = 1'b1;
    special_cmd = 1'b1;
    put(8'h10, 32'h0000_0355);
    quiet();
    repeat (40) @(negedge clk_sys);
    `CHK("general call abort", 1'b1, transmit_abort_flag)
    abort_clear = 1'b1;
    special_cmd = 1'b0;
    @(negedge clk_sys);
    abort_clear = 1'b0;
    repeat (40) @(negedge clk_sys);
    ops.delete();
    ents.delete();
    ents.push_back(11'h377);
    put(8'h10, 32'h0000_0377);
    quiet();
    void'(build(repeated_start_allow));
    cmp_ops();
    `CHK("no abort", 1'b0, transmit_abort_flag)
    $display("test general call done");
    stop_test();
  end
endmodule
`default_nettype wire
